// ---- rtl/tmrb_timer.sv ----
// Timer B: 16-bit timer/counter with capture, autoreload and APB registers
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module tmrb_timer (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins
	input  wire logic        ext_trigger_pin,
	output logic             timer_out,
	output logic             timer_irq
);

	// ==========================================================
	// Bus decode
	logic        wr_en;
	logic        rd_en;
	logic [15:0] timer_control_reg_q;
	logic [15:0] count_value_q;
	logic [15:0] capture_reload_value_q;
	logic [15:0] compare_value_q;
	logic [1:0]  mode_q;
	logic [15:0] wdata16;
	logic        down_phase_q;
	logic        out_q;
	logic        out_prev_q;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign wdata16 = pwdata[15:0];

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == tmrb_pkg::CTRL_ADDR) || (a == tmrb_pkg::COUNT_ADDR) ||
			(a == tmrb_pkg::RELOAD_ADDR) || (a == tmrb_pkg::CMP_ADDR) ||
			(a == tmrb_pkg::MODE_ADDR);
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
			input logic [3:0] st);
		merge = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
	endfunction

	assign pslverr = psel && penable && !mapped(paddr);

	// ==========================================================
	// Pin synchroniser and edge detection
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	tmrb_pkg::tmrb_evt_t evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_s3_q <= 1'b1;
		end else begin
			pin_s1_q <= ext_trigger_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Control bit aliases
	logic       sel_capture;
	logic       irq_en;
	logic       run;
	logic       ext_en;
	logic       down_count_enable;
	logic       clk_out_en;
	logic       pwm_mode;
	logic       cmp_mode;
	logic [2:0] prescale;

	assign sel_capture = timer_control_reg_q[tmrb_pkg::CR_SEL];
	assign irq_en      = timer_control_reg_q[tmrb_pkg::CR_IRQEN];
	assign run         = timer_control_reg_q[tmrb_pkg::CR_RUN];
	assign ext_en      = timer_control_reg_q[tmrb_pkg::CR_EXEN];
	assign down_count_enable        = timer_control_reg_q[tmrb_pkg::CR_DOWN_COUNT_ENABLE];
	assign clk_out_en  = timer_control_reg_q[tmrb_pkg::CR_OUTEN];
	assign prescale    = timer_control_reg_q[tmrb_pkg::CR_PS_LO +: 3];
	assign pwm_mode    = mode_q[tmrb_pkg::MD_PWM];
	assign cmp_mode    = mode_q[tmrb_pkg::MD_CMP];

	// Pin events ignored unless enabled; PWM falls replace pin in PWM reload mode
	assign evt = {
		ext_en && !down_count_enable && !pin_s2_q && pin_s3_q
			&& !(pwm_mode && !sel_capture),
		ext_en && pwm_mode && !sel_capture && out_prev_q && !out_q
	};

	// ==========================================================
	// Prescaler: divide by 4^prescale[1:0]; the top prescale bit is ignored
	logic [7:0] ps_cnt_q;
	logic [7:0] ps_limit;
	logic       tick;

	assign ps_limit = 8'(tmrb_pkg::PS_ONE << {prescale[1:0], 1'b0}) - 8'h01;
	assign tick     = run && (ps_cnt_q >= ps_limit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_cnt_q <= 8'h00;
		end else if (!run || tick) begin
			ps_cnt_q <= 8'h00;
		end else begin
			ps_cnt_q <= ps_cnt_q + 8'h01;
		end
	end

	// ==========================================================
	// Direction and limits
	tmrb_pkg::tmrb_dir_t dir;
	logic [15:0] reload_limit;
	logic        at_top;
	logic        at_bottom;
	logic        ovf;

	assign reload_limit = cmp_mode ? compare_value_q : capture_reload_value_q;
	assign at_top       = (count_value_q == tmrb_pkg::MAX16);
	assign at_bottom    = (count_value_q == reload_limit);

	always_comb begin
		if (!tick) begin
			dir = tmrb_pkg::TMRB_HOLD;
		end else if (!down_count_enable) begin
			dir = tmrb_pkg::TMRB_UP;
		end else if (pwm_mode || cmp_mode) begin
			dir = down_phase_q ? tmrb_pkg::TMRB_DOWN : tmrb_pkg::TMRB_UP;
		end else begin
			dir = pin_s2_q ? tmrb_pkg::TMRB_UP : tmrb_pkg::TMRB_DOWN;
		end
	end

	always_comb begin
		case (dir)
			tmrb_pkg::TMRB_UP:   ovf = at_top;
			tmrb_pkg::TMRB_DOWN: ovf = (count_value_q == tmrb_pkg::ZERO16) || at_bottom;
			tmrb_pkg::TMRB_HOLD: ovf = 1'b0;
			default:             ovf = 1'b0;
		endcase
	end

	// ==========================================================
	// Counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value_q <= tmrb_pkg::ZERO16;
		end else if (wr_en && paddr == tmrb_pkg::COUNT_ADDR) begin
			count_value_q <= merge(count_value_q, wdata16, pstrb);
		end else if (evt.pin_fall && !sel_capture) begin
			count_value_q <= tmrb_pkg::ZERO16;
		end else begin
			case (dir)
				tmrb_pkg::TMRB_UP: begin
					if (ovf) begin
						count_value_q <= reload_limit;
					end else begin
						count_value_q <= count_value_q + 16'h0001;
					end
				end
				tmrb_pkg::TMRB_DOWN: begin
					if (ovf) begin
						count_value_q <= tmrb_pkg::MAX16;
					end else begin
						count_value_q <= count_value_q - 16'h0001;
					end
				end
				default: count_value_q <= count_value_q;
			endcase
		end
	end

	// Up/down phase for internally steered modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			down_phase_q <= 1'b0;
		end else if (!(down_count_enable && (pwm_mode || cmp_mode))) begin
			down_phase_q <= 1'b0;
		end else if (dir == tmrb_pkg::TMRB_UP && at_top) begin
			down_phase_q <= 1'b1;
		end else if (dir == tmrb_pkg::TMRB_DOWN && ovf) begin
			down_phase_q <= 1'b0;
		end
	end

	// Output toggles on overflow in clock-output mode, else compare output in PWM mode, else holds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q      <= 1'b0;
			out_prev_q <= 1'b0;
		end else begin
			out_prev_q <= out_q;
			if (clk_out_en && ovf) begin
				out_q <= !out_q;
			end else if (pwm_mode && !clk_out_en) begin
				out_q <= (count_value_q < compare_value_q);
			end
		end
	end
	assign timer_out = out_q;

	// ==========================================================
	// Registers
	logic ctrl_wr;
	assign ctrl_wr = wr_en && paddr == tmrb_pkg::CTRL_ADDR;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_reload_value_q <= tmrb_pkg::ZERO16;
		end else if (evt.pin_fall && sel_capture) begin
			capture_reload_value_q <= count_value_q;
		end else if (wr_en && paddr == tmrb_pkg::RELOAD_ADDR) begin
			capture_reload_value_q <= merge(capture_reload_value_q, wdata16, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_value_q <= tmrb_pkg::ZERO16;
			mode_q          <= 2'b00;
		end else if (wr_en && paddr == tmrb_pkg::CMP_ADDR) begin
			compare_value_q <= merge(compare_value_q, wdata16, pstrb);
		end else if (wr_en && paddr == tmrb_pkg::MODE_ADDR && pstrb[0]) begin
			mode_q <= pwdata[1:0];
		end
	end

	// Control bits and flags: hardware set wins over software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_reg_q <= tmrb_pkg::CTRL_RST;
		end else begin
			if (ctrl_wr && pstrb[0]) begin
				timer_control_reg_q[7:0] <= wdata16[7:0];
			end
			if (ctrl_wr && pstrb[1]) begin
				timer_control_reg_q[15:8] <= {5'h00, wdata16[10:8]};
			end
			if (ovf) begin
				timer_control_reg_q[tmrb_pkg::CR_OVF] <= 1'b1;
			end
			if (evt.pin_fall || evt.pwm_fall) begin
				timer_control_reg_q[tmrb_pkg::CR_EXF] <= 1'b1;
			end
		end
	end

	// Interrupt request
	assign timer_irq = irq_en && ((timer_control_reg_q[tmrb_pkg::CR_OVF] && !clk_out_en)
		|| timer_control_reg_q[tmrb_pkg::CR_EXF]);

	// ==========================================================
	// Read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				tmrb_pkg::CTRL_ADDR:   prdata <= {16'h0000, timer_control_reg_q};
				tmrb_pkg::COUNT_ADDR:  prdata <= {16'h0000, count_value_q};
				tmrb_pkg::RELOAD_ADDR: prdata <= {16'h0000, capture_reload_value_q};
				tmrb_pkg::CMP_ADDR:    prdata <= {16'h0000, compare_value_q};
				tmrb_pkg::MODE_ADDR:   prdata <= {30'h0000_0000, mode_q};
				default:               prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// ---- rtl/tmrb_pkg.sv ----
// Package: register map, field positions and types for the timer block
package tmrb_pkg;

	// Register offsets (byte addresses, index times four)
	localparam logic [7:0] CTRL_IDX    = 8'h0a;
	localparam logic [7:0] CTRL_ADDR   = 8'h28;
	localparam logic [7:0] COUNT_ADDR  = 8'h2c;
	localparam logic [7:0] RELOAD_ADDR = 8'h30;
	localparam logic [7:0] CMP_ADDR    = 8'h34;
	localparam logic [7:0] MODE_ADDR   = 8'h38;

	// Control register fields
	localparam int CR_SEL   = 0;
	localparam int CR_IRQEN = 1;
	localparam int CR_RUN   = 2;
	localparam int CR_EXEN  = 3;
	localparam int CR_DOWN_COUNT_ENABLE  = 4;
	localparam int CR_OUTEN = 5;
	localparam int CR_EXF   = 6;
	localparam int CR_OVF   = 7;
	localparam int CR_PS_LO = 8;

	// Mode register fields
	localparam int MD_PWM = 0;
	localparam int MD_CMP = 1;

	// Reset values and constants
	localparam logic [15:0] CTRL_RST  = 16'h0000;
	localparam logic [15:0] ZERO16    = 16'h0000;
	localparam logic [15:0] MAX16     = 16'hffff;
	localparam logic [7:0]  PS_ONE    = 8'h01;

	// Pin events travelling together
	typedef struct packed {
		logic pin_fall;
		logic pwm_fall;
	} tmrb_evt_t;

	typedef enum logic [1:0] {
		TMRB_UP,
		TMRB_DOWN,
		TMRB_HOLD
	} tmrb_dir_t;

endpackage

// ---- tb/tmrb_pin_model.sv ----
// Partner model: drives the external trigger pin
`timescale 1ns/1ps
module tmrb_pin_model (
	// Clock
	input  wire logic pclk,
	// Pin
	output logic      ext_trigger_pin
);
	initial ext_trigger_pin = 1'b1;
	// Pin level sets count direction
	task set_lvl(input logic v);
		@(posedge pclk);
		ext_trigger_pin <= v;
	endtask
	// Negative edge held past the synchroniser
	task fall();
		set_lvl(1'b0);
		repeat (5) @(posedge pclk);
		ext_trigger_pin <= 1'b1;
	endtask
endmodule

// ---- tb/tmrb_timer_props.sv ----
// Checker: port properties of the timer block
`timescale 1ns/1ps
module tmrb_timer_props (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// Pins
	input  wire logic        ext_trigger_pin,
	input  wire logic        timer_out,
	input  wire logic        timer_irq
);
	logic [7:0] ctl_q;
	logic       acc;
	logic       ok;
	logic       rda;
	assign acc = psel && penable;
	assign rda = acc && !pwrite;
	assign ok = paddr inside {tmrb_pkg::CTRL_ADDR, tmrb_pkg::COUNT_ADDR,
		tmrb_pkg::RELOAD_ADDR, tmrb_pkg::CMP_ADDR, tmrb_pkg::MODE_ADDR};
	// ==========
	// Shadow of software control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 8'h00;
		end else if (acc && pwrite && paddr == tmrb_pkg::CTRL_ADDR && pstrb[0]) begin
			ctl_q <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// Properties
	property p_irq_gate; timer_irq |-> ctl_q[tmrb_pkg::CR_IRQEN]; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
	property p_bad_err; acc && !ok |-> pslverr; endproperty
	a_bad_err: assert property (p_bad_err) else $error("no error on bad address");
	property p_good_ok; acc && ok |-> !pslverr; endproperty
	a_good_ok: assert property (p_good_ok) else $error("error on good address");
	property p_bad_zero; rda && !ok |-> prdata == 32'h0000_0000; endproperty
	a_bad_zero: assert property (p_bad_zero) else $error("bad address data");
	property p_hi; rda |-> prdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_ctl;
		rda && paddr == tmrb_pkg::CTRL_ADDR |-> prdata[5:0] == ctl_q[5:0];
	endproperty
	a_ctl: assert property (p_ctl) else $error("control readback");
	property p_rdy; psel |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state");
	property p_rst; $rose(presetn) |-> !timer_irq && !timer_out; endproperty
	a_rst: assert property (p_rst) else $error("outputs after reset");
	c_irq: cover property (timer_irq);
	c_err: cover property (pslverr);
	c_out: cover property (timer_out);
endmodule

// ---- tb/tmrb_timer_bench.sv ----
// Testbench: self-checking bench of the timer block
`timescale 1ns/1ps
module tmrb_timer_bench;
	localparam logic [7:0]  CT  = tmrb_pkg::CTRL_ADDR;
	localparam logic [7:0]  CN  = tmrb_pkg::COUNT_ADDR;
	localparam logic [7:0]  RL  = tmrb_pkg::RELOAD_ADDR;
	localparam logic [15:0] SEL = 16'h0001;
	localparam logic [15:0] IEN = 16'h0002;
	localparam logic [15:0] RUN = 16'h0004;
	localparam logic [15:0] EXN = 16'h0008;
	localparam logic [15:0] DCN = 16'h0010;
	localparam logic [15:0] OEN = 16'h0020;
	localparam logic [15:0] EVF = 16'h0040;
	localparam logic [15:0] OVF = 16'h0080;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        tout;
	logic        irq;
	logic [15:0] rd;
	logic [15:0] c;
	logic        err;
	int          errors;
	int          n_checks;
	tmrb_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_trigger_pin(pin), .timer_out(tout),
		.timer_irq(irq));
	tmrb_pin_model pin_u (.pclk(pclk), .ext_trigger_pin(pin));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ==========
	// Shared tasks
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function logic [15:0] rng(input logic [15:0] v, input logic [15:0] lo, hi);
		return {15'h0000, (v >= lo && v < hi)};
	endfunction
	task xf(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata[15:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task start(input logic [15:0] cnt, input logic [15:0] ctl);
		xf(1'b1, CN, cnt);
		xf(1'b1, CT, ctl);
	endtask
	// ==========
	// Scenarios
	task t_reset();
		xf(1'b0, CT, 16'h0000);
		chk("ctrl reset", rd, tmrb_pkg::CTRL_RST);
		xf(1'b0, 8'h3c, 16'h0000);
		chk("unmapped", {15'h0000, err}, 16'h0001);
	endtask
	task t_hold();
		start(16'h0000, RUN);
		repeat (20) @(posedge pclk);
		xf(1'b1, CT, 16'h0000);
		xf(1'b0, CN, 16'h0000);
		c = rd;
		chk("run span", rng(c, 16'd20, 16'd28), 16'h0001);
		repeat (20) @(posedge pclk);
		xf(1'b0, CN, 16'h0000);
		chk("held", rd, c);
	endtask
	task t_ovf(input logic [15:0] ex, input logic [15:0] ei);
		xf(1'b1, RL, 16'h1234);
		start(16'hfff0, RUN | IEN | ex);
		repeat (30) @(posedge pclk);
		#1;
		chk("irq", {15'h0000, irq}, ei);
		chk("clock out", {15'h0000, tout}, ex >> 5);
		xf(1'b0, CT, 16'h0000);
		chk("ovf flag", rd & OVF, OVF);
		xf(1'b1, CT, IEN);
		xf(1'b0, CN, 16'h0000);
		chk("reloaded", rng(rd, 16'h1234, 16'h1260), 16'h0001);
		#1;
		chk("irq clear", {15'h0000, irq}, 16'h0000);
	endtask
	task t_pin(input logic [15:0] ctl, input logic [7:0] a, input logic [15:0] lo, hi);
		xf(1'b1, RL, 16'h0000);
		start(16'h5000, RUN | ctl);
		pin_u.fall();
		repeat (4) @(posedge pclk);
		xf(1'b1, CT, ctl);
		xf(1'b0, a, 16'h0000);
		chk("pin event", rng(rd, lo, hi), 16'h0001);
	endtask
	task t_down();
		pin_u.set_lvl(1'b0);
		start(16'h8000, RUN | DCN);
		repeat (20) @(posedge pclk);
		xf(1'b0, CN, 16'h0000);
		c = rd;
		chk("down", rng(c, 16'h7fc0, 16'h8000), 16'h0001);
		pin_u.set_lvl(1'b1);
		repeat (20) @(posedge pclk);
		xf(1'b0, CN, 16'h0000);
		chk("up again", rng(rd, c + 16'h0001, c + 16'h0040), 16'h0001);
		xf(1'b1, CT, 16'h0000);
	endtask
	task t_pwm();
		xf(1'b1, RL, 16'h0000);
		xf(1'b1, tmrb_pkg::CMP_ADDR, 16'h0010);
		xf(1'b1, tmrb_pkg::MODE_ADDR, 16'h0001);
		start(16'h0008, RUN | EXN);
		#1;
		chk("pwm high", {15'h0000, tout}, 16'h0001);
		pin_u.fall();
		repeat (30) @(posedge pclk);
		#1;
		chk("pwm low", {15'h0000, tout}, 16'h0000);
		xf(1'b0, CT, 16'h0000);
		chk("pwm event", rd & EVF, EVF);
		xf(1'b1, CT, EXN);
		xf(1'b0, CN, 16'h0000);
		chk("no pin reload", rng(rd, 16'h0028, 16'h0040), 16'h0001);
	endtask
	task t_cmp();
		xf(1'b1, RL, 16'h1111);
		xf(1'b1, tmrb_pkg::CMP_ADDR, 16'h4000);
		xf(1'b1, tmrb_pkg::MODE_ADDR, 16'h0002);
		start(16'hfff0, RUN);
		repeat (30) @(posedge pclk);
		xf(1'b1, CT, 16'h0000);
		xf(1'b0, CN, 16'h0000);
		chk("compare reload", rng(rd, 16'h4000, 16'h4030), 16'h0001);
		xf(1'b1, tmrb_pkg::MODE_ADDR, 16'h0000);
	endtask
	task t_force();
		xf(1'b1, CT, IEN | EVF);
		#1;
		chk("forced irq", {15'h0000, irq}, 16'h0001);
		xf(1'b1, CT, EVF);
		#1;
		chk("masked irq", {15'h0000, irq}, 16'h0000);
	endtask
	// ==========
	// Run control
	task final_report();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		final_report();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		errors = 0;
		n_checks = 0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_hold();
		t_ovf(16'h0000, 16'h0001);
		t_ovf(OEN, 16'h0000);
		t_pin(SEL | EXN, RL, 16'h5000, 16'h5020);
		t_pin(EXN, CN, 16'h0000, 16'h0020);
		t_pin(16'h0000, CN, 16'h5000, 16'h5040);
		t_down();
		t_pwm();
		t_cmp();
		t_force();
		final_report();
	end
endmodule
bind tmrb_timer tmrb_timer_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_trigger_pin(ext_trigger_pin), .timer_out(timer_out), .timer_irq(timer_irq));
